// *** rif_pkg.sv ***
// shared constants and types for the receiver flag and pin routing block
package rif_pkg;
    localparam int ADDR_W = 7;
    localparam logic [6:0] OFS_ROUTE_A = 7'h25;
    localparam logic [6:0] OFS_ROUTE_B = 7'h26;
    localparam logic [6:0] OFS_FLAGS_LO = 7'h27;
    localparam logic [6:0] OFS_FLAGS_HI = 7'h28;
    localparam logic [6:0] OFS_THRESH = 7'h29;
    localparam logic [6:0] OFS_TO_START = 7'h2A;
    localparam logic [6:0] OFS_TO_PAYLOAD = 7'h2B;
    // field positions, low flag byte
    localparam int B_MODE = 7;
    localparam int B_RXRDY = 6;
    localparam int B_LOCK = 4;
    localparam int B_RSSI = 3;
    localparam int B_TOUT = 2;
    localparam int B_INTER = 1;
    localparam int B_SYNC = 0;
    // field positions, high flag byte
    localparam int B_FULL = 7;
    localparam int B_NEMPTY = 6;
    localparam int B_LEVEL = 5;
    localparam int B_OVR = 4;
    localparam int B_PAYLOAD = 2;
    localparam int B_CRC = 1;
    localparam int B_SUPPLY_LOW_FLAG = 0;
    localparam logic [7:0] RST_ROUTE = 8'h00;
    localparam logic [3:0] RST_ROUTE_B = 4'h0;
    localparam logic [7:0] RST_THRESH = 8'hE4;
    localparam logic [7:0] RST_TIMEOUT = 8'h00;
    localparam logic [6:0] QUEUE_FULL_CNT = 7'h42;
    localparam int TO_SCALE_SH = 4;
    localparam int TO_CNT_W = 12;
    typedef logic [2:0] rif_clksel_t;
    localparam rif_clksel_t CLK_DIV1 = 3'h0;
    localparam rif_clksel_t CLK_RC = 3'h6;
    localparam rif_clksel_t CLK_OFF = 3'h7;
    typedef logic [5:0][3:0] rif_src_t;
    typedef enum logic [1:0] {MODE_SLEEP, MODE_STBY, MODE_SYNTH, MODE_RX} rif_mode_e;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rif_bus_s;
    typedef struct packed {
        rif_mode_e mode;
        logic pkt_mode;
        logic xo_run;
        logic pll_lock;
        logic rssi_sampling;
        logic rx_settled;
        logic inter_mode;
        logic sync_det;
        logic fifo_ovf;
        logic last_byte;
        logic crc_on;
        logic crc_ok;
        logic check_fail_keep;
        logic bit_tick;
    } rif_stat_s;
endpackage : rif_pkg

// *** rif_clk_div.sv ***
// clock output pin selector and divider
module rif_clk_div (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire rif_pkg::rif_clksel_t sel_i,
    input wire logic rc_i,
    output logic pin_o,
    output logic rc_en_o
);
    import rif_pkg::*;
    logic [4:0] cnt;
    logic rc_s1;
    logic rc_s2;
    logic pin_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 5'h00;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
        end else begin
            rc_s1 <= rc_i;
            rc_s2 <= rc_s1;
        end
    end

    // bit k of the counter toggles every 2^k cycles, giving divide by 2^(k+1)
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_q <= 1'b0;
        end else if (sel_i == CLK_RC) begin
            pin_q <= rc_s2;
        end else if (sel_i == CLK_OFF || sel_i == CLK_DIV1) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= cnt[sel_i - 3'h1];
        end
    end

    // undivided setting passes the clock itself; a flop cannot rebuild it
    assign pin_o = (sel_i == CLK_DIV1) ? clk_i : pin_q;
    assign rc_en_o = (sel_i == CLK_RC);
endmodule : rif_clk_div

// *** rif_timeout.sv ***
// receive timeout counter in units of sixteen bit periods
module rif_timeout (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [7:0] limit_i,
    input wire logic tick_i,
    output logic expire_o
);
    import rif_pkg::*;
    logic run;
    logic [TO_CNT_W-1:0] cnt;
    logic [TO_CNT_W-1:0] next_cnt;
    logic [TO_CNT_W-1:0] span;

    assign next_cnt = cnt + 12'h001;
    assign span = TO_CNT_W'(limit_i) << TO_SCALE_SH;

    // a zero limit never arms, which disables the timeout
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run <= 1'b0;
            cnt <= 12'h000;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (start_i) begin
                run <= (limit_i != RST_TIMEOUT);
                cnt <= 12'h000;
            end else if (stop_i) begin
                run <= 1'b0;
            end else if (run && tick_i) begin
                if (next_cnt == span) begin
                    run <= 1'b0;
                    expire_o <= 1'b1;
                end else begin
                    cnt <= next_cnt;
                end
            end
        end
    end
endmodule : rif_timeout

// *** rif_top.sv ***
// receiver event flags, pin routing and clock output selection
//
// Operation
// - two-bit route per pin, mode dependent
// - clock output divide, RC, or off
// - mode reached set per target mode
// - mode reached clears on change, resets set
// - receive ready after settling, clears leaving
// - lock flag follows lock in synth/receive
// - level flag above threshold, host clearable
// - start timeout, sixteen bit units, zero off
// - payload timeout after level event, zero off
// - timeout read-only, clears on exit/empty
// - intermediate flag tracks intermediate state
// - sync flag, clear rules, continuous-only write
// - full flag exactly at 66 bytes
// - nonempty flag when any byte stored
// - level flag when count above threshold
// - overrun flag; write one clears queue
// - payload done after last byte if accepted
// - check pass on good checksum
// - supply low sticky, host write clears
// - threshold register sets level trigger
// - failed check flushes and restarts reception
// - measured level is unsigned half-dB magnitude
module rif_top (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire rif_pkg::rif_bus_s BUS_I,
    output logic [7:0] RDATA_O,
    input wire rif_pkg::rif_stat_s STAT_I,
    input wire logic [7:0] RSSI_VAL_I,
    input wire logic [6:0] FIFO_CNT_I,
    input wire logic [6:0] FIFO_THR_I,
    input wire logic LOW_BAT_I,
    input wire logic RC_CLK_I,
    input wire rif_pkg::rif_src_t CONT_SRC_I,
    input wire rif_pkg::rif_src_t PKT_SRC_I,
    output logic [5:0] DIO_O,
    output logic CLK_PIN_O,
    output logic RC_EN_O,
    output logic FIFO_CLEAR_O,
    output logic RX_RESTART_O
);
    import rif_pkg::*;

    logic [7:0] route_a, signal_level_threshold, start_timeout_count, payload_timeout_count;
    logic [3:0] route_b;
    rif_clksel_t clk_pin_select;
    logic [11:0] pin_route;
    rif_mode_e mode_q;
    logic mode_chg, in_rx, rx_entered, rx_left, emptied, reach_cond, level_above, check_bad;
    logic start_expire, payload_expire, supply_low_flag_s1, supply_low_flag_s2;
    logic wr_lo, wr_hi, clr_rssi, clr_sync, clr_ovr, clr_supply_low_flag;
    logic mode_reached_flag, receive_ready_flag, synth_lock_flag, rssi_flag, timeout_flag;
    logic intermediate_state_flag, sync_match_flag, queue_full_flag, queue_nonempty_flag;
    logic queue_level_flag, queue_overrun_flag, payload_done_flag, check_pass_flag, supply_low_flag;
    logic [7:0] flags_lo, flags_hi, next_rdata;

    // register writes
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            route_a <= RST_ROUTE;
            route_b <= RST_ROUTE_B;
            clk_pin_select <= CLK_OFF;
            signal_level_threshold <= RST_THRESH;
            start_timeout_count <= RST_TIMEOUT;
            payload_timeout_count <= RST_TIMEOUT;
        end else if (BUS_I.wr) begin
            unique case (BUS_I.addr)
                OFS_ROUTE_A: route_a <= BUS_I.wdata;
                OFS_ROUTE_B: begin
                    route_b <= BUS_I.wdata[7:4];
                    clk_pin_select <= BUS_I.wdata[2:0];
                end
                OFS_THRESH: signal_level_threshold <= BUS_I.wdata;
                OFS_TO_START: start_timeout_count <= BUS_I.wdata;
                OFS_TO_PAYLOAD: payload_timeout_count <= BUS_I.wdata;
                default: ;
            endcase
        end
    end

    assign wr_lo = BUS_I.wr && (BUS_I.addr == OFS_FLAGS_LO);
    assign wr_hi = BUS_I.wr && (BUS_I.addr == OFS_FLAGS_HI);
    assign clr_rssi = wr_lo && BUS_I.wdata[B_RSSI];
    // sync flag is read-only while the packet engine owns it
    assign clr_sync = wr_lo && BUS_I.wdata[B_SYNC] && !STAT_I.pkt_mode;
    assign clr_ovr = wr_hi && BUS_I.wdata[B_OVR];
    assign clr_supply_low_flag = wr_hi && BUS_I.wdata[B_SUPPLY_LOW_FLAG];

    // mode tracking
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode_q <= MODE_SLEEP;
        end else begin
            mode_q <= STAT_I.mode;
        end
    end

    assign mode_chg = (STAT_I.mode != mode_q);
    assign in_rx = (STAT_I.mode == MODE_RX);
    assign rx_entered = in_rx && (mode_q != MODE_RX);
    assign rx_left = !in_rx && (mode_q == MODE_RX);
    assign emptied = queue_nonempty_flag && (FIFO_CNT_I == 7'h00);

    always_comb begin
        unique case (STAT_I.mode)
            MODE_SLEEP: reach_cond = 1'b1;
            MODE_STBY: reach_cond = STAT_I.xo_run;
            MODE_SYNTH: reach_cond = STAT_I.pll_lock;
            MODE_RX: reach_cond = STAT_I.rssi_sampling;
        endcase
    end

    // smaller magnitude means a stronger signal
    assign level_above = (RSSI_VAL_I < signal_level_threshold);
    assign check_bad = STAT_I.crc_on && !STAT_I.crc_ok && !STAT_I.check_fail_keep;

    // mode and synthesiser flags
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode_reached_flag <= 1'b1;
        end else if (mode_chg) begin
            mode_reached_flag <= 1'b0;
        end else if (reach_cond) begin
            mode_reached_flag <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            receive_ready_flag <= 1'b0;
        end else if (!in_rx) begin
            receive_ready_flag <= 1'b0;
        end else if (STAT_I.rx_settled) begin
            receive_ready_flag <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            synth_lock_flag <= 1'b0;
            intermediate_state_flag <= 1'b0;
        end else begin
            synth_lock_flag <= (in_rx || STAT_I.mode == MODE_SYNTH) && STAT_I.pll_lock;
            intermediate_state_flag <= STAT_I.inter_mode;
        end
    end

    // signal level and sync flags
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rssi_flag <= 1'b0;
        end else if (in_rx && level_above) begin
            rssi_flag <= 1'b1;
        end else if (!in_rx || clr_rssi) begin
            rssi_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sync_match_flag <= 1'b0;
        end else if (in_rx && STAT_I.sync_det) begin
            sync_match_flag <= 1'b1;
        end else if (!in_rx || emptied || clr_sync) begin
            sync_match_flag <= 1'b0;
        end
    end

    // timeouts
    rif_timeout u_start_to (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .start_i(rx_entered),
        .stop_i(!in_rx || rssi_flag),
        .limit_i(start_timeout_count),
        .tick_i(STAT_I.bit_tick),
        .expire_o(start_expire)
    );

    rif_timeout u_payload_to (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .start_i(in_rx && level_above && !rssi_flag),
        .stop_i(!in_rx || payload_done_flag),
        .limit_i(payload_timeout_count),
        .tick_i(STAT_I.bit_tick),
        .expire_o(payload_expire)
    );

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            timeout_flag <= 1'b0;
        end else if (in_rx && (start_expire || payload_expire)) begin
            timeout_flag <= 1'b1;
        end else if (!in_rx || emptied) begin
            timeout_flag <= 1'b0;
        end
    end

    // queue state flags
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            queue_full_flag <= 1'b0;
            queue_nonempty_flag <= 1'b0;
            queue_level_flag <= 1'b0;
        end else begin
            queue_full_flag <= (FIFO_CNT_I == QUEUE_FULL_CNT);
            queue_nonempty_flag <= (FIFO_CNT_I != 7'h00);
            queue_level_flag <= (FIFO_CNT_I > FIFO_THR_I);
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            queue_overrun_flag <= 1'b0;
        end else if (STAT_I.fifo_ovf && STAT_I.mode != MODE_SLEEP) begin
            queue_overrun_flag <= 1'b1;
        end else if (clr_ovr) begin
            queue_overrun_flag <= 1'b0;
        end
    end

    // payload completion and checksum
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            payload_done_flag <= 1'b0;
            check_pass_flag <= 1'b0;
        end else begin
            if (in_rx && STAT_I.last_byte && !check_bad) begin
                payload_done_flag <= 1'b1;
            end else if (emptied) begin
                payload_done_flag <= 1'b0;
            end
            if (in_rx && STAT_I.last_byte && STAT_I.crc_on && STAT_I.crc_ok) begin
                check_pass_flag <= 1'b1;
            end else if (emptied) begin
                check_pass_flag <= 1'b0;
            end
        end
    end

    // flush on overrun clear or on a rejected packet
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            FIFO_CLEAR_O <= 1'b0;
            RX_RESTART_O <= 1'b0;
        end else begin
            FIFO_CLEAR_O <= clr_ovr || (in_rx && STAT_I.last_byte && check_bad);
            RX_RESTART_O <= in_rx && STAT_I.last_byte && check_bad;
        end
    end

    // supply detector is asynchronous to this clock
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            supply_low_flag_s1 <= 1'b0;
            supply_low_flag_s2 <= 1'b0;
        end else begin
            supply_low_flag_s1 <= LOW_BAT_I;
            supply_low_flag_s2 <= supply_low_flag_s1;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            supply_low_flag <= 1'b0;
        end else if (supply_low_flag_s2) begin
            supply_low_flag <= 1'b1;
        end else if (clr_supply_low_flag) begin
            supply_low_flag <= 1'b0;
        end
    end

    // pin routing
    assign pin_route = {route_a, route_b};

    generate
        for (genvar p = 0; p < 6; p++) begin : g_pin
            logic [1:0] sel;
            assign sel = pin_route[11 - 2 * p -: 2];
            always_ff @(posedge CLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    DIO_O[p] <= 1'b0;
                end else begin
                    DIO_O[p] <= STAT_I.pkt_mode ? PKT_SRC_I[p][sel] : CONT_SRC_I[p][sel];
                end
            end
        end
    endgenerate

    rif_clk_div u_clk_div (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .sel_i(clk_pin_select),
        .rc_i(RC_CLK_I),
        .pin_o(CLK_PIN_O),
        .rc_en_o(RC_EN_O)
    );

    // read port
    always_comb begin
        flags_lo = 8'h00;
        flags_lo[B_MODE] = mode_reached_flag;
        flags_lo[B_RXRDY] = receive_ready_flag;
        flags_lo[B_LOCK] = synth_lock_flag;
        flags_lo[B_RSSI] = rssi_flag;
        flags_lo[B_TOUT] = timeout_flag;
        flags_lo[B_INTER] = intermediate_state_flag;
        flags_lo[B_SYNC] = sync_match_flag;
        flags_hi = 8'h00;
        flags_hi[B_FULL] = queue_full_flag;
        flags_hi[B_NEMPTY] = queue_nonempty_flag;
        flags_hi[B_LEVEL] = queue_level_flag;
        flags_hi[B_OVR] = queue_overrun_flag;
        flags_hi[B_PAYLOAD] = payload_done_flag;
        flags_hi[B_CRC] = check_pass_flag;
        flags_hi[B_SUPPLY_LOW_FLAG] = supply_low_flag;
        unique case (BUS_I.addr)
            OFS_ROUTE_A: next_rdata = route_a;
            OFS_ROUTE_B: next_rdata = {route_b, 1'b0, clk_pin_select};
            OFS_FLAGS_LO: next_rdata = flags_lo;
            OFS_FLAGS_HI: next_rdata = flags_hi;
            OFS_THRESH: next_rdata = signal_level_threshold;
            OFS_TO_START: next_rdata = start_timeout_count;
            OFS_TO_PAYLOAD: next_rdata = payload_timeout_count;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (BUS_I.rd) begin
            RDATA_O <= next_rdata;
        end
    end

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    a_mode_chg_clear: assert property (mode_chg |=> !mode_reached_flag)
        else $error("mode reached flag not cleared on mode change");
    a_sleep_reached: assert property (STAT_I.mode == MODE_SLEEP && !mode_chg |=> mode_reached_flag)
        else $error("mode reached flag missing in sleep");
    a_rxrdy_leave: assert property (rx_left |=> !receive_ready_flag)
        else $error("receive ready flag kept after leaving receive");
    a_lock_idle: assert property (STAT_I.mode inside {MODE_SLEEP, MODE_STBY} |=> !synth_lock_flag)
        else $error("lock flag set outside synth or receive");
    a_level_set: assert property (in_rx && level_above |=> rssi_flag)
        else $error("level flag not set above threshold");
    a_timeout_exit: assert property (rx_left |=> !timeout_flag)
        else $error("timeout flag kept after leaving receive");
    a_full_exact: assert property (FIFO_CNT_I == QUEUE_FULL_CNT |=> queue_full_flag)
        else $error("full flag missing at full count");
    a_level_low: assert property (FIFO_CNT_I <= FIFO_THR_I |=> !queue_level_flag)
        else $error("queue level flag above count");
    a_ovr_clear: assert property (clr_ovr && !STAT_I.fifo_ovf |=> !queue_overrun_flag && FIFO_CLEAR_O)
        else $error("overrun clear did not flush");
    a_check_fail: assert property (in_rx && STAT_I.last_byte && check_bad && !payload_done_flag
        |=> RX_RESTART_O && FIFO_CLEAR_O && !payload_done_flag)
        else $error("failed check not flushed");
    a_supply_low_flag_sticky: assert property (supply_low_flag && !clr_supply_low_flag |=> supply_low_flag)
        else $error("supply low flag dropped without clear");
    a_clk_off: assert property (clk_pin_select == CLK_OFF [*2] |-> !CLK_PIN_O)
        else $error("clock pin toggles while off");

    c_payload: cover property ($rose(payload_done_flag));
    c_timeout: cover property ($rose(timeout_flag));
    c_restart: cover property (RX_RESTART_O);
    c_ovr_clear: cover property (queue_overrun_flag ##1 clr_ovr);
endmodule : rif_top

// *** rif_core_model.sv ***
// radio core stand-in: mode dependent status levels and a bit period tick
module rif_core_model (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire rif_pkg::rif_mode_e mode_i,
    output logic xo_run_o,
    output logic lock_o,
    output logic sampling_o,
    output logic settled_o,
    output logic tick_o
);
    import rif_pkg::*;
    rif_mode_e prev;
    logic [3:0] age;
    logic [1:0] div;
    logic held;
    // age restarts on every mode change, so each status level lags the request
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev <= MODE_SLEEP;
            age <= 4'h0;
            div <= 2'h0;
        end else begin
            prev <= mode_i;
            div <= div + 2'h1;
            age <= (mode_i != prev) ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
        end
    end
    // levels drop at once on a new request; the old mode's age must not leak through
    assign held = (mode_i == prev);
    assign xo_run_o = held && (mode_i != MODE_SLEEP) && (age > 4'h1);
    assign lock_o = held && (mode_i == MODE_SYNTH || mode_i == MODE_RX) && (age > 4'h3);
    assign sampling_o = held && (mode_i == MODE_RX) && (age > 4'h5);
    assign settled_o = held && (mode_i == MODE_RX) && (age > 4'h8);
    // four clock cycles per bit keeps the timeout runs short
    assign tick_o = (div == 2'h3);
endmodule : rif_core_model

// *** rif_top_tb.sv ***
// self-checking bench for the receiver flag and pin routing block
module rif_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rif_pkg::*;
    logic clk, arst_n, lb, cpin, rcen, fclr, rrst, xo, lk, smp, stl, tk, cp_prev;
    logic rc = 1'b0;
    rif_bus_s bus;
    rif_stat_s st, stat;
    logic [7:0] rssi, rdata;
    logic [6:0] cnt, thr;
    logic [5:0] dio;
    rif_src_t csrc, psrc;
    int err_total, samples_checked, cyc, n;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h07, 8'h80, 8'h00, 8'hE4, 8'h00, 8'h00, 8'h00};
    rif_top dut (.CLK_I(clk), .ARST_N_I(arst_n), .BUS_I(bus), .RDATA_O(rdata), .STAT_I(stat),
        .RSSI_VAL_I(rssi), .FIFO_CNT_I(cnt), .FIFO_THR_I(thr), .LOW_BAT_I(lb), .RC_CLK_I(rc),
        .CONT_SRC_I(csrc), .PKT_SRC_I(psrc), .DIO_O(dio), .CLK_PIN_O(cpin), .RC_EN_O(rcen),
        .FIFO_CLEAR_O(fclr), .RX_RESTART_O(rrst));
    rif_core_model core (.clk_i(clk), .arst_n_i(arst_n), .mode_i(st.mode), .xo_run_o(xo), .lock_o(lk),
        .sampling_o(smp), .settled_o(stl), .tick_o(tk));
    always_comb begin
        stat = st;
        stat.xo_run = xo;
        stat.pll_lock = lk;
        stat.rssi_sampling = smp;
        stat.rx_settled = stl;
        stat.bit_tick = tk;
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rc <= (cyc % 3 == 0) ? ~rc : rc;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk8
    task automatic chkb(input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chkb
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : idle
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask : wr
    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk8(e, rdata);
    endtask : rd
    task automatic count_high(input int k);
        n = 0;
        repeat (k) begin
            #1;
            n = n + int'(rrst === 1'b1);
            @(posedge clk);
        end
    endtask : count_high
    initial begin
        arst_n = 1'b0;
        bus = '0;
        st = '0;
        rssi = 8'hFF;
        cnt = 7'h00;
        thr = 7'h0A;
        lb = 1'b0;
        csrc = {6{4'h4}};
        psrc = '0;
        idle(12);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(7'h25 + 7'(i), rst_tab[i]);
        $display("reset values done");
        wr(7'h2A, 8'h01);
        wr(7'h29, 8'h80);
        rd(7'h29, 8'h80);
        @(posedge clk) st.mode <= MODE_RX;
        idle(1);
        rd(7'h27, 8'h00);
        idle(12);
        rd(7'h27, 8'hD0);
        idle(70);
        rd(7'h27, 8'hD4);
        @(posedge clk) st.sync_det <= 1'b1;
        st.inter_mode <= 1'b1;
        @(posedge clk) st.sync_det <= 1'b0;
        rd(7'h27, 8'hD7);
        wr(7'h27, 8'h01);
        rd(7'h27, 8'hD6);
        @(posedge clk) st.inter_mode <= 1'b0;
        @(posedge clk) rssi <= 8'h40;
        idle(3);
        rd(7'h27, 8'hDC);
        @(posedge clk) rssi <= 8'hFF;
        wr(7'h27, 8'h0C);
        rd(7'h27, 8'hD4);
        @(posedge clk) st.mode <= MODE_STBY;
        idle(12);
        rd(7'h27, 8'h80);
        $display("mode flags done");
        @(posedge clk) st.fifo_ovf <= 1'b1;
        @(posedge clk) st.fifo_ovf <= 1'b0;
        rd(7'h28, 8'h10);
        wr(7'h28, 8'h10);
        chkb(1'b1, fclr);
        rd(7'h28, 8'h00);
        @(posedge clk) cnt <= 7'h42;
        idle(2);
        rd(7'h28, 8'hE0);
        @(posedge clk) cnt <= 7'h0A;
        idle(2);
        rd(7'h28, 8'h40);
        $display("queue flags done");
        @(posedge clk) st.mode <= MODE_RX;
        st.crc_on <= 1'b1;
        st.last_byte <= 1'b1;
        @(posedge clk) st.last_byte <= 1'b0;
        count_high(4);
        chk8(8'h01, 8'(n));
        rd(7'h28, 8'h40);
        @(posedge clk) st.check_fail_keep <= 1'b1;
        st.last_byte <= 1'b1;
        @(posedge clk) st.last_byte <= 1'b0;
        count_high(2);
        chk8(8'h00, 8'(n));
        rd(7'h28, 8'h44);
        @(posedge clk) st.crc_ok <= 1'b1;
        st.last_byte <= 1'b1;
        @(posedge clk) st.last_byte <= 1'b0;
        idle(2);
        rd(7'h28, 8'h46);
        @(posedge clk) cnt <= 7'h00;
        idle(2);
        rd(7'h28, 8'h00);
        wr(7'h2B, 8'h01);
        @(posedge clk) rssi <= 8'h40;
        idle(70);
        rd(7'h27, 8'hDC);
        @(posedge clk) lb <= 1'b1;
        idle(5);
        @(posedge clk) lb <= 1'b0;
        idle(5);
        rd(7'h28, 8'h01);
        wr(7'h28, 8'h01);
        rd(7'h28, 8'h00);
        $display("packet flags done");
        wr(7'h25, 8'hAA);
        wr(7'h26, 8'hAE);
        rd(7'h26, 8'hA6);
        idle(2);
        chk8(8'h3F, {2'b00, dio});
        chkb(1'b1, rcen);
        @(posedge clk) st.pkt_mode <= 1'b1;
        idle(2);
        chk8(8'h00, {2'b00, dio});
        wr(7'h26, 8'hA1);
        idle(2);
        n = 0;
        cp_prev = cpin;
        repeat (8) begin
            @(posedge clk);
            #1;
            n = n + int'(cpin !== cp_prev);
            cp_prev = cpin;
        end
        chk8(8'h08, 8'(n));
        wr(7'h26, 8'hA7);
        idle(2);
        chkb(1'b0, cpin);
        chkb(1'b0, rcen);
        $display("routing and clock done");
        results();
    end
endmodule : rif_top_tb
